//--- drps_pkg.sv
/*
 * Constants of the dual row pointer sequencer and the row pointer shift
 * register that the top instantiates once for each side of the array.
 * Assumes every strobe and level arrives synchronous to clk.
 */
// Notes on behaviour
// - The right pointer moves on by one row at each rising edge of its shift clock.
// - A low right home input at a right shift clock rising edge puts the right pointer on row 1.
// - A low left home input at a left shift clock rising edge puts the left pointer on row 1.
// - The left pointer moves on by one row at each rising edge of its shift clock.
// - While the right drive enable is high the right pointer drives reset and select of its row.
// - The left drive enable is high active and lets the left pointer drive its row's lines.
// - The switchboard state changes only at rising edges of the switchboard clock.
// - The switchboard home input is low active and sampled at the switchboard clock rising edge.
// - With toggling on, the crossbar bit inverts at each switchboard edge, from its initial value.
`default_nettype none

package drps_pkg;
    // -------------------------------------------------------------------
    // array geometry
    // -------------------------------------------------------------------
    localparam int ROWS_DEFAULT = 4560;
    localparam int ROW_NUM_WIDTH = 13;
    localparam int HOME_ROW_BIT = 0;
    localparam logic [ROW_NUM_WIDTH-1:0] HOME_ROW_NUMBER = 13'h0001;
    // -------------------------------------------------------------------
    // reset values
    // -------------------------------------------------------------------
    // a strobe seen high when reset lifts must not count as a fresh edge
    localparam logic STROBE_PREV_RESET = 1'b1;
    localparam logic CROSSBAR_RESET = 1'b0;
    localparam logic FLAG_RESET = 1'b0;
endpackage : drps_pkg

module drps_row_pointer
    import drps_pkg::*;
#(
    parameter int ROWS = ROWS_DEFAULT,
    parameter int IDX_W = ROW_NUM_WIDTH
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic step_pulse,
    input wire logic home_n,
    output logic [ROWS-1:0] onehot_reg,
    output logic [IDX_W-1:0] index_reg
);
    localparam logic [IDX_W-1:0] INDEX_PAST_END = IDX_W'(ROWS + 1);

    // -------------------------------------------------------------------
    // one-hot pointer; the token falls off the far end, no wrap
    // -------------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            onehot_reg <= ROWS'(1);
        end else if (step_pulse) begin
            if (!home_n) begin
                onehot_reg <= ROWS'(1) << HOME_ROW_BIT;
            end else begin
                onehot_reg <= onehot_reg << 1;
            end
        end
    end

    // row number kept beside the token so nobody must encode 4560 bits
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            index_reg <= IDX_W'(HOME_ROW_NUMBER);
        end else if (step_pulse) begin
            if (!home_n) begin
                index_reg <= IDX_W'(HOME_ROW_NUMBER);
            end else if (index_reg != INDEX_PAST_END) begin
                index_reg <= index_reg + IDX_W'(1);
            end
        end
    end
endmodule : drps_row_pointer

`default_nettype wire

//--- drps_sequencer.sv
/*
 * Top of the dual row pointer sequencer: strobe edge detection, the two
 * row pointers, the Y switchboard crossbar bit and the registered row
 * reset and select line drivers.
 * Assumes an external timing generator drives every strobe, home input
 * and enable synchronous to clk, with strobe highs and lows one clk or more.
 */
`default_nettype none

module drps_sequencer
    import drps_pkg::*;
#(
    parameter int ROWS = ROWS_DEFAULT,
    parameter int IDX_W = ROW_NUM_WIDTH
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic right_row_shift_clock,
    input wire logic right_row_pointer_home_n,
    input wire logic right_row_drive_enable,
    input wire logic left_row_shift_clock,
    input wire logic left_row_pointer_home_n,
    input wire logic left_row_drive_enable,
    input wire logic switch_y_clock,
    input wire logic switch_home_n,
    input wire logic crossbar_init_value,
    input wire logic crossbar_toggle_enable,
    input wire logic row_reset_pulse,
    input wire logic row_select_pulse,
    output logic [ROWS-1:0] row_reset_lines_reg,
    output logic [ROWS-1:0] row_select_lines_reg,
    output logic crossbar_ctrl_reg,
    output logic [IDX_W-1:0] right_row_index,
    output logic [IDX_W-1:0] left_row_index,
    output logic enable_conflict_reg
);
    logic right_prev_reg;
    logic left_prev_reg;
    logic switch_prev_reg;
    logic right_step;
    logic left_step;
    logic switch_step;
    logic [ROWS-1:0] right_ptr;
    logic [ROWS-1:0] left_ptr;
    logic [ROWS-1:0] drive_rows;
    logic crossbar_next;

    // -------------------------------------------------------------------
    // strobe edge detection
    // -------------------------------------------------------------------
    // strobes are already synchronous, so one stage of history is enough
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            right_prev_reg <= STROBE_PREV_RESET;
            left_prev_reg <= STROBE_PREV_RESET;
            switch_prev_reg <= STROBE_PREV_RESET;
        end else begin
            right_prev_reg <= right_row_shift_clock;
            left_prev_reg <= left_row_shift_clock;
            switch_prev_reg <= switch_y_clock;
        end
    end

    // rising edges as one-cycle pulses
    assign right_step = right_row_shift_clock & ~right_prev_reg;
    assign left_step = left_row_shift_clock & ~left_prev_reg;
    assign switch_step = switch_y_clock & ~switch_prev_reg;

    // -------------------------------------------------------------------
    // row pointers
    // -------------------------------------------------------------------
    // right pointer shift
    drps_row_pointer #(
        .ROWS(ROWS),
        .IDX_W(IDX_W)
    ) u_right_ptr (
        .clk(clk),
        .sys_rst(sys_rst),
        .step_pulse(right_step),
        .home_n(right_row_pointer_home_n),
        .onehot_reg(right_ptr),
        .index_reg(right_row_index)
    );

    drps_row_pointer #(
        .ROWS(ROWS),
        .IDX_W(IDX_W)
    ) u_left_ptr (
        .clk(clk),
        .sys_rst(sys_rst),
        .step_pulse(left_step),
        .home_n(left_row_pointer_home_n),
        .onehot_reg(left_ptr),
        .index_reg(left_row_index)
    );

    // -------------------------------------------------------------------
    // switchboard crossbar bit
    // -------------------------------------------------------------------
    // home or toggle select
    always_comb begin
        crossbar_next = crossbar_ctrl_reg;
        if (!switch_home_n) begin
            crossbar_next = crossbar_init_value;
        end else if (crossbar_toggle_enable) begin
            crossbar_next = ~crossbar_ctrl_reg;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            crossbar_ctrl_reg <= CROSSBAR_RESET;
        end else if (switch_step) begin
            crossbar_ctrl_reg <= crossbar_next;
        end
    end

    // -------------------------------------------------------------------
    // row line drivers
    // -------------------------------------------------------------------
    // gate pointers by enables
    // both enabled on different rows would hit two rows; that is flagged only
    assign drive_rows = (right_row_drive_enable ? right_ptr : '0)
                      | (left_row_drive_enable ? left_ptr : '0);

    // registered so the pins never glitch while a pointer moves
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            row_reset_lines_reg <= '0;
            row_select_lines_reg <= '0;
        end else begin
            row_reset_lines_reg <= row_reset_pulse ? drive_rows : '0;
            row_select_lines_reg <= row_select_pulse ? drive_rows : '0;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            enable_conflict_reg <= FLAG_RESET;
        end else begin
            enable_conflict_reg <= right_row_drive_enable & left_row_drive_enable
                                 & (right_ptr != left_ptr);
        end
    end

    // -------------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    sequence right_rise_s;
        !right_row_shift_clock ##1 right_row_shift_clock;
    endsequence

    sequence left_rise_s;
        !left_row_shift_clock ##1 left_row_shift_clock;
    endsequence

    sequence switch_rise_s;
        !switch_y_clock ##1 switch_y_clock;
    endsequence

    right_home_a: assert property (
        right_rise_s ##0 !right_row_pointer_home_n
        |=> right_row_index == HOME_ROW_NUMBER && right_ptr[HOME_ROW_BIT])
        else $error("right pointer not on row 1 after home");

    right_shift_a: assert property (
        right_rise_s ##0 right_row_pointer_home_n ##0 right_row_index < IDX_W'(ROWS)
        |=> right_row_index == $past(right_row_index) + IDX_W'(1)
            && right_ptr == $past(right_ptr) << 1)
        else $error("right pointer did not advance one row");

    left_home_a: assert property (
        left_rise_s ##0 !left_row_pointer_home_n
        |=> left_row_index == HOME_ROW_NUMBER && left_ptr[HOME_ROW_BIT])
        else $error("left pointer not on row 1 after home");

    left_shift_a: assert property (
        left_rise_s ##0 left_row_pointer_home_n ##0 left_row_index < IDX_W'(ROWS)
        |=> left_row_index == $past(left_row_index) + IDX_W'(1)
            && left_ptr == $past(left_ptr) << 1)
        else $error("left pointer did not advance one row");

    left_hold_a: assert property (
        !(left_row_shift_clock && !left_prev_reg) |=> $stable(left_row_index))
        else $error("left pointer moved without an edge");

    ptr_hold_a: assert property (
        !(right_row_shift_clock && !right_prev_reg) |=> $stable(right_row_index))
        else $error("right pointer moved without an edge");

    right_drive_a: assert property (
        right_row_drive_enable && !left_row_drive_enable && row_select_pulse
        |=> row_select_lines_reg == $past(right_ptr))
        else $error("right pointer row not selected");

    left_drive_a: assert property (
        left_row_drive_enable && !right_row_drive_enable && row_reset_pulse
        |=> row_reset_lines_reg == $past(left_ptr))
        else $error("left pointer row not reset");

    idle_lines_a: assert property (
        !right_row_drive_enable && !left_row_drive_enable
        |=> row_reset_lines_reg == '0 && row_select_lines_reg == '0)
        else $error("row line driven with both enables low");

    crossbar_home_a: assert property (
        switch_rise_s ##0 !switch_home_n |=> crossbar_ctrl_reg == $past(crossbar_init_value))
        else $error("crossbar bit not loaded from initial value");

    crossbar_toggle_a: assert property (
        switch_rise_s ##0 switch_home_n ##0 crossbar_toggle_enable
        |=> crossbar_ctrl_reg != $past(crossbar_ctrl_reg))
        else $error("crossbar bit did not toggle");

    crossbar_hold_a: assert property (
        !(switch_y_clock && !switch_prev_reg) |=> $stable(crossbar_ctrl_reg))
        else $error("crossbar bit changed without an edge");

    // checked both ways, so a flag raised without a conflict is caught too
    conflict_flag_a: assert property (
        enable_conflict_reg == $past(right_row_drive_enable && left_row_drive_enable
                                     && right_ptr != left_ptr))
        else $error("enable conflict flag wrong");
endmodule : drps_sequencer

`default_nettype wire

//--- drps_timing_gen.sv
/*
 * Timing generator model for the dual row pointer sequencer: strobes,
 * home inputs, drive enables and row pulses.
 * Assumes a free running clk; every level moves 1 ns after its rising edge.
 */
`default_nettype none

module drps_timing_gen (
    input wire logic clk,
    output logic right_row_shift_clock,
    output logic right_row_pointer_home_n,
    output logic left_row_shift_clock,
    output logic left_row_pointer_home_n,
    output logic switch_y_clock,
    output logic switch_home_n,
    output var logic right_row_drive_enable,
    output var logic left_row_drive_enable,
    output var logic row_reset_pulse,
    output var logic row_select_pulse
);
    timeunit 1ns;
    timeprecision 1ns;
    // -------------------------------------------------------------------
    // strobe and home levels, index 0 right, index 1 left
    // -------------------------------------------------------------------
    logic [1:0] stb = 2'h0;
    logic [1:0] hom = 2'h3;
    assign right_row_shift_clock = stb[0];
    assign right_row_pointer_home_n = hom[0];
    assign left_row_shift_clock = stb[1];
    assign left_row_pointer_home_n = hom[1];
    assign switch_y_clock = stb[1];
    assign switch_home_n = hom[1];
    // idle: nothing enabled, no pulse
    initial begin
        {right_row_drive_enable, left_row_drive_enable} = 2'h0;
        {row_reset_pulse, row_select_pulse} = 2'h0;
    end
    // one strobe high for hi cycles; home only held while the strobe is up
    task automatic step(input int s, input logic h, input int hi);
        @(posedge clk);
        #1;
        stb[s] = 1'b1;
        hom[s] = h;
        repeat (hi) @(posedge clk);
        #1;
        stb[s] = 1'b0;
        hom[s] = 1'b1;
    endtask : step
    // one-cycle pulses; caller pairs enables only on one row
    task automatic drive(input logic er, input logic el, input logic rp, input logic sp);
        @(posedge clk);
        #1;
        {right_row_drive_enable, left_row_drive_enable, row_reset_pulse} = {er, el, rp};
        row_select_pulse = sp;
        @(posedge clk);
        #1;
        {right_row_drive_enable, left_row_drive_enable} = 2'h0;
        {row_reset_pulse, row_select_pulse} = 2'h0;
    endtask : drive
endmodule : drps_timing_gen

`default_nettype wire

//--- test_dual_row_pointer_sequencer.sv
/*
 * Self-checking bench for the sequencer built with eight rows.
 * Assumes drps_timing_gen drives the strobes; the bench owns reset and crossbar setup.
 */
`default_nettype none

module test_dual_row_pointer_sequencer
    import drps_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // -------------------------------------------------------------------
    // clock, reset and wiring
    // -------------------------------------------------------------------
    localparam int ROWS = 8;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic crossbar_init_value = 1'b0;
    logic crossbar_toggle_enable = 1'b0;
    wire logic right_row_shift_clock, right_row_pointer_home_n, right_row_drive_enable;
    wire logic left_row_shift_clock, left_row_pointer_home_n, left_row_drive_enable;
    wire logic switch_y_clock, switch_home_n, row_reset_pulse, row_select_pulse;
    wire logic [ROWS-1:0] row_reset_lines_reg, row_select_lines_reg;
    wire logic [ROW_NUM_WIDTH-1:0] right_row_index, left_row_index;
    wire logic crossbar_ctrl_reg, enable_conflict_reg;
    int n_mismatch = 0;
    int total_checks = 0;
    int cyc = 0;
    int exp_r = 1;
    int exp_l = 1;
    logic exp_xb = 1'b0;
    always #50 clk = ~clk;
    drps_sequencer #(.ROWS(ROWS), .IDX_W(ROW_NUM_WIDTH)) drps_sequencer_i (.clk, .sys_rst,
        .right_row_shift_clock, .right_row_pointer_home_n, .right_row_drive_enable,
        .left_row_shift_clock, .left_row_pointer_home_n, .left_row_drive_enable,
        .switch_y_clock, .switch_home_n, .crossbar_init_value, .crossbar_toggle_enable,
        .row_reset_pulse, .row_select_pulse, .row_reset_lines_reg, .row_select_lines_reg,
        .crossbar_ctrl_reg, .right_row_index, .left_row_index, .enable_conflict_reg);
    drps_timing_gen drps_timing_gen_i (.clk, .right_row_shift_clock,
        .right_row_pointer_home_n, .left_row_shift_clock, .left_row_pointer_home_n,
        .switch_y_clock, .switch_home_n, .right_row_drive_enable, .left_row_drive_enable,
        .row_reset_pulse, .row_select_pulse);
    // -------------------------------------------------------------------
    // checking helpers
    // -------------------------------------------------------------------
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // pointer runs off the end and stays empty; only home brings it back
    function automatic int nxt(input int v, input logic h);
        return !h ? 1 : ((v > ROWS) ? ROWS + 1 : v + 1);
    endfunction : nxt
    task automatic stp(input int s, input logic h, input int hi);
        drps_timing_gen_i.step(s, h, hi);
        if (s == 0) exp_r = nxt(exp_r, h);
        else exp_l = nxt(exp_l, h);
        if (s == 1) exp_xb = !h ? crossbar_init_value : exp_xb ^ crossbar_toggle_enable;
        chk("right_row_index", 16'(right_row_index), 16'(exp_r));
        chk("left_row_index", 16'(left_row_index), 16'(exp_l));
        chk("crossbar_ctrl_reg", 16'(crossbar_ctrl_reg), 16'(exp_xb));
    endtask : stp
    // -------------------------------------------------------------------
    // scenarios
    // -------------------------------------------------------------------
    task automatic t_reset;
        chk("right_row_index", 16'(right_row_index), 16'h1);
        chk("left_row_index", 16'(left_row_index), 16'h1);
        chk("row_select_lines_reg", 16'(row_select_lines_reg), 16'h0);
    endtask : t_reset
    // home, walk past the last row, home, one long strobe, home again
    task automatic t_walk(input int s, input logic init, input logic tog);
        crossbar_init_value = init;
        crossbar_toggle_enable = tog;
        stp(s, 1'b0, 1);
        repeat (ROWS + 1) stp(s, 1'b1, 1);
        stp(s, 1'b0, 1);
        stp(s, 1'b1, 3);
        stp(s, 1'b0, 1);
    endtask : t_walk
    task automatic lin(input logic er, input logic el, input logic rp, input logic sp);
        logic [15:0] rows;
        rows = (er ? 16'h1 << (exp_r - 1) : 16'h0) | (el ? 16'h1 << (exp_l - 1) : 16'h0);
        drps_timing_gen_i.drive(er, el, rp, sp);
        chk("row_select_lines_reg", 16'(row_select_lines_reg), sp ? rows : 16'h0);
        chk("row_reset_lines_reg", 16'(row_reset_lines_reg), rp ? rows : 16'h0);
        chk("enable_conflict_reg", 16'(enable_conflict_reg), 16'h0);
        @(posedge clk);
        #1;
        chk("row_select_lines_reg", 16'(row_select_lines_reg), 16'h0);
    endtask : lin
    // pointers on different rows, each side alone, then both on one row
    task automatic t_lines;
        stp(0, 1'b1, 1);
        stp(0, 1'b1, 1);
        lin(1'b1, 1'b0, 1'b0, 1'b1);
        lin(1'b1, 1'b0, 1'b1, 1'b0);
        lin(1'b0, 1'b1, 1'b1, 1'b1);
        lin(1'b0, 1'b0, 1'b1, 1'b1);
        stp(0, 1'b0, 1);
        lin(1'b1, 1'b1, 1'b1, 1'b1);
    endtask : t_lines
    // reset in mid-run while a strobe is held high: it must not count again
    task automatic t_rerun;
        fork
            drps_timing_gen_i.step(0, 1'b1, 4);
            begin
                repeat (2) @(posedge clk);
                #1;
                sys_rst = 1'b1;
                @(posedge clk);
                #1;
                sys_rst = 1'b0;
            end
        join
        exp_r = 1;
        exp_l = 1;
        exp_xb = 1'b0;
        t_reset();
        stp(0, 1'b1, 1);
    endtask : t_rerun
    // -------------------------------------------------------------------
    // run control
    // -------------------------------------------------------------------
    task automatic complete_run;
        if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : complete_run
    // the whole run needs about 120 cycles; a hang stops here
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            n_mismatch++;
            complete_run();
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        t_reset();
        t_walk(0, 1'b1, 1'b1);
        t_walk(1, 1'b1, 1'b1);
        t_walk(1, 1'b0, 1'b0);
        t_lines();
        t_rerun();
        complete_run();
    end
endmodule : test_dual_row_pointer_sequencer

`default_nettype wire
